// ==== dv/cpcr_host.sv ====
`timescale 1ns/1ps
module cpcr_host (
   input  wire       sys_clk,
   input  wire [7:0] reg_rdata,
   input  wire       reg_hit,
   output reg        reg_wr_en,
   output reg        reg_rd_en,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata
);
   initial {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = 18'h0;
   // one-cycle write strobe launched on the falling edge
   task wr(input [7:0] a, input [7:0] d);
      reg [7:0] v;
      v = d;
      if (a == 8'h67) v[1:0] = 2'b00;
      if (a == 8'h66 && &v[7:6]) v[7] = 1'b0;
      if (a == 8'h66 && &v[5:4]) v[5] = 1'b0;
      @(negedge sys_clk);
      {reg_wr_en, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(negedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_wdata <= ~v; // idle data never shows the last byte
   endtask
   // answer registered at the strobe edge, taken half a cycle later
   task rd(input [7:0] a, output [7:0] d, output h);
      @(negedge sys_clk);
      {reg_rd_en, reg_addr} <= {1'b1, a};
      @(negedge sys_clk);
      reg_rd_en <= 1'b0;
      d = reg_rdata;
      h = reg_hit;
   endtask
endmodule

// ==== dv/cpcr_regs_monitor.sv ====
`timescale 1ns/1ps
module cpcr_regs_monitor (
   input wire       sys_clk,
   input wire       rst_b,
   input wire       reg_wr_en,
   input wire       reg_rd_en,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_hit,
   input wire       multifunction_pin_c_out,
   input wire       core_clock_sel,
   input wire [1:0] clock_divider_input_sel,
   input wire [4:0] pll_divider_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // write strobes decoded per offset
   wire w65 = reg_wr_en && reg_addr == 8'h65;
   wire w66 = reg_wr_en && reg_addr == 8'h66;
   chk_hit_mapped: assert property ((reg_rd_en || reg_wr_en) && reg_addr inside {[8'h65:8'h67]}
      |=> reg_hit) else $error("mapped access without hit");
   chk_hit_unmapped: assert property ((reg_wr_en || reg_rd_en) &&
      !(reg_addr inside {[8'h65:8'h67]}) |=> !reg_hit) else $error("hit on unmapped offset");
   chk_hit_idle: assert property (!reg_wr_en && !reg_rd_en |=> !reg_hit)
      else $error("hit without access");
   chk_core_sel: assert property (w65 |=> core_clock_sel == $past(reg_wdata[0]))
      else $error("core clock select wrong");
   chk_gpo_level: assert property (w65 |=> multifunction_pin_c_out == $past(reg_wdata[1]))
      else $error("pin c level wrong");
   chk_cdiv_sel: assert property (w66 |=> clock_divider_input_sel == $past(reg_wdata[7:6]))
      else $error("divider source wrong");
   chk_pll_code: assert property (w66 && reg_wdata[3:1] != 3'h0 |->
      ##2 pll_divider_n == {1'b0, $past(reg_wdata[3:0], 2)}) else $error("pll n wrong");
   chk_pll_wrap: assert property (w66 && reg_wdata[3:1] == 3'h0 |->
      ##2 pll_divider_n == {4'h8, $past(reg_wdata[0], 2)}) else $error("pll n wrap wrong");
   chk_pll_rst: assert property ($rose(rst_b) |-> pll_divider_n == 5'h02)
      else $error("pll n reset wrong");
endmodule
bind cpcr_regs cpcr_regs_monitor i_mon (
   .sys_clk                 (sys_clk),
   .rst_b                   (rst_b),
   .reg_wr_en               (reg_wr_en),
   .reg_rd_en               (reg_rd_en),
   .reg_addr                (reg_addr),
   .reg_wdata               (reg_wdata),
   .reg_hit                 (reg_hit),
   .multifunction_pin_c_out (multifunction_pin_c_out),
   .core_clock_sel          (core_clock_sel),
   .clock_divider_input_sel (clock_divider_input_sel),
   .pll_divider_n           (pll_divider_n)
);

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   reg         sys_clk = 1'b0;
   reg         rst_b = 1'b0;
   reg         iface_select = 1'b0;
   reg         multifunction_pin_a_in = 1'b1;
   reg         multifunction_pin_b_in = 1'b0;
   reg         multifunction_pin_d_in = 1'b0;
   reg  [7:0]  legacy_attack_ms = 8'h2c;
   wire        reg_wr_en, reg_rd_en, reg_hit, multifunction_pin_c_out, multifunction_pin_c_oe;
   wire        audio_serial_data_in, core_clock_sel, atk_use_new;
   wire [7:0]  reg_addr, reg_wdata, reg_rdata;
   wire [1:0]  clock_divider_input_sel, pll_reference_input_sel;
   wire [4:0]  pll_divider_n;
   wire [15:0] left_attack_ms;
   integer     errors = 0;
   integer     tests_run = 0;
   integer     i;
   reg  [7:0]  rdv;
   reg         hit;
   reg  [7:0]  base_ms [0:3];
   always #12.5 sys_clk = ~sys_clk;
   cpcr_regs i_dut (.*);
   cpcr_host i_host (.*);
   task chk(input [15:0] got, input [15:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rchk(input [7:0] a, input h, input [7:0] exp);
      i_host.rd(a, rdv, hit);
      chk({hit, rdv}, {h, exp});
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      #200000;
      errors = errors + 1;
      end_sim;
   end
   initial
   begin
      {base_ms[0], base_ms[1], base_ms[2], base_ms[3]} = 32'h07080a0b;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (6) @(negedge sys_clk); // straps need stable pins after release
      rchk(8'h65, 1'b1, 8'h40);
      rchk(8'h66, 1'b1, 8'h02);
      rchk(8'h67, 1'b1, 8'h00);
      $display("test reset done");
      multifunction_pin_d_in = 1'b1;
      i_host.wr(8'h65, 8'hff);
      rchk(8'h65, 1'b1, 8'h7f);
      chk({multifunction_pin_c_oe, multifunction_pin_c_out, audio_serial_data_in}, 3'h7);
      multifunction_pin_d_in = 1'b0;
      repeat (3) @(negedge sys_clk);
      rchk(8'h65, 1'b1, 8'h77);
      chk(audio_serial_data_in, 1'b0);
      iface_select = 1'b1;
      repeat (4) @(negedge sys_clk);
      rchk(8'h65, 1'b1, 8'h37);
      chk({multifunction_pin_c_oe, audio_serial_data_in}, 2'h0);
      iface_select = 1'b0;
      i_host.wr(8'h65, 8'h01);
      chk({multifunction_pin_c_oe, multifunction_pin_c_out, core_clock_sel}, 3'h1);
      $display("test pins done");
      for (i = 0; i < 16; i = i + 1)
      begin
         rdv = i % 3;
         i_host.wr(8'h66, {rdv[1:0], 2'd2 - rdv[1:0], i[3:0]});
         chk({clock_divider_input_sel, pll_reference_input_sel}, {rdv[1:0], 2'd2 - rdv[1:0]});
         @(negedge sys_clk);
         chk(pll_divider_n, (i < 2) ? 5'h10 + i[0] : {1'b0, i[3:0]});
      end
      $display("test clock done");
      for (i = 0; i < 32; i = i + 1)
      begin
         i_host.wr(8'h67, {1'b1, i[4:0], 2'b11});
         @(negedge sys_clk);
         chk(left_attack_ms, {8'h00, base_ms[i[4:3]]} << i[2:0]);
      end
      chk(atk_use_new, 1'b1);
      rchk(8'h67, 1'b1, 8'hfc);
      i_host.wr(8'h67, 8'h00);
      @(negedge sys_clk);
      chk(left_attack_ms, 16'h002c);
      legacy_attack_ms = 8'h51;
      repeat (2) @(negedge sys_clk);
      chk(left_attack_ms, 16'h0051);
      $display("test attack done");
      i_host.wr(8'h68, 8'hff);
      rchk(8'h66, 1'b1, 8'h2f);
      rchk(8'h68, 1'b0, 8'h00);
      rchk(8'h64, 1'b0, 8'h00);
      $display("test unmapped done");
      end_sim;
   end
endmodule

// ==== logic/cpcr_consts.vh ====
`ifndef CPCR_CONSTS_VH
`define CPCR_CONSTS_VH
// register offsets on the control map
`define CPCR_OFS_PIN_STRAP     8'h65
`define CPCR_OFS_CLK_SRC       8'h66
`define CPCR_OFS_ATTACK        8'h67
// pin/strap register fields
`define CPCR_BIT_STRAP_B       7
`define CPCR_BIT_STRAP_A       6
`define CPCR_BIT_GPI_EN        5
`define CPCR_BIT_SDATA_EN      4
`define CPCR_BIT_GPI_VAL       3
`define CPCR_BIT_GPO_EN        2
`define CPCR_BIT_GPO_VAL       1
`define CPCR_BIT_CORE_SEL      0
// clock source register fields
`define CPCR_CDIV_SEL_MSB      7
`define CPCR_CDIV_SEL_LSB      6
`define CPCR_PLL_SEL_MSB       5
`define CPCR_PLL_SEL_LSB       4
`define CPCR_PLLN_MSB          3
`define CPCR_PLLN_LSB          0
// attack register fields
`define CPCR_BIT_ATK_SRC       7
`define CPCR_ATK_BASE_MSB      6
`define CPCR_ATK_BASE_LSB      5
`define CPCR_ATK_MUL_MSB       4
`define CPCR_ATK_MUL_LSB       2
// reset values
`define CPCR_RST_PIN_CTL       6'h00
`define CPCR_RST_CLK_SRC       8'h02
`define CPCR_RST_ATTACK        6'h00
`define CPCR_RST_PLL_N         5'h02
// edges after internal release before the pin synchroniser holds a real sample
`define CPCR_STRAP_WAIT        2'h2
// clock source codes
`define CPCR_SRC_MCLK          2'h0
`define CPCR_SRC_IO_TWO        2'h1
`define CPCR_SRC_BCLK          2'h2
// baseline attack times in ms
`define CPCR_ATK_MS_0          8'h07
`define CPCR_ATK_MS_1          8'h08
`define CPCR_ATK_MS_2          8'h0a
`define CPCR_ATK_MS_3          8'h0b
`endif

// ==== logic/cpcr_regs.v ====
// Overview of operation
// - read-only bits 7 and 6 show strap levels of pins b and a at reset
// - pin d input-enable bit makes pin d a general input; resets zero
// - serial-data-input bit routes pin d to the audio serial data input
// - read-only bit 3 returns pin d level while used as general input
// - output-enable bit makes pin c a general-purpose output
// - pin c driven high or low following the output-level bit
// - strap and pin bits act only in two-wire mode, select input low
// - bit 0 picks core clock: zero pll divided, one clock divider
// - clock divider input: 00 master clock, 01 gpio two, 10 bit clock
// - pll reference input: 00 master clock, 01 gpio two, 10 bit clock
// - pll divider n: 0000 gives 16, 0001 gives 17, else binary value
// - attack source bit: zero older register, one this register
// - baseline attack 7, 8, 10 or 11 ms by code; resets 00
// - multiplier is two to the power of the three-bit code
`timescale 1ns/1ps
`include "cpcr_consts.vh"
module cpcr_regs (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire       reg_wr_en,
   input  wire       reg_rd_en,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_hit,
   input  wire       iface_select,
   input  wire       multifunction_pin_a_in,
   input  wire       multifunction_pin_b_in,
   input  wire       multifunction_pin_d_in,
   output wire       multifunction_pin_c_out,
   output wire       multifunction_pin_c_oe,
   output wire       audio_serial_data_in,
   output wire       core_clock_sel,
   output wire [1:0] clock_divider_input_sel,
   output wire [1:0] pll_reference_input_sel,
   output reg  [4:0] pll_divider_n,
   output wire       atk_use_new,
   input  wire [7:0] legacy_attack_ms,
   output reg  [15:0] left_attack_ms
);
   reg        rst_meta_ff;
   reg        rst_sync_ff;
   wire       rst_int_b;
   wire [3:0] pins_sync;
   reg        strap_a_ff;
   reg        strap_b_ff;
   reg        strap_done_ff;
   reg  [1:0] strap_wait_ff;
   reg  [5:0] pin_ctl_ff;   // writable bits 5:0 at their own places, slot 3 unused
   reg  [7:0] clk_src_ff;
   reg  [5:0] attack_ff;
   reg  [7:0] nxt_rdata;
   reg  [4:0] nxt_pll_n;
   reg  [15:0] nxt_attack;
   wire       two_wire;
   wire       gpi_val;

   // reset released through two flops, assertion stays asynchronous
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_int_b = rst_sync_ff;

   // pins and mode select come from outside the clock domain
   cpcr_sync2 #(
      .W(4)
   ) u_pin_sync (
      .sys_clk (sys_clk),
      .rst_b   (rst_int_b),
      .din     ({iface_select, multifunction_pin_d_in,
                 multifunction_pin_b_in, multifunction_pin_a_in}),
      .dout    (pins_sync)
   );

   assign two_wire = ~pins_sync[3];

   // straps caught once, after the pin synchroniser has filled
   always @(posedge sys_clk or negedge rst_int_b)
   begin
      if (!rst_int_b)
      begin
         strap_a_ff    <= 1'b0;
         strap_b_ff    <= 1'b0;
         strap_done_ff <= 1'b0;
         strap_wait_ff <= 2'h0;
      end
      else if (!strap_done_ff)
      begin
         // synchroniser leaves reset with us, so its first two outputs are stale
         strap_wait_ff <= strap_wait_ff + 2'h1;
         if (strap_wait_ff == `CPCR_STRAP_WAIT)
         begin
            strap_done_ff <= 1'b1;
            strap_a_ff    <= pins_sync[0];
            strap_b_ff    <= pins_sync[1];
         end
      end
   end

   // register writes; reserved code 11 trusted to host, low attack bits dropped
   always @(posedge sys_clk or negedge rst_int_b)
   begin
      if (!rst_int_b)
      begin
         pin_ctl_ff <= `CPCR_RST_PIN_CTL;
         clk_src_ff <= `CPCR_RST_CLK_SRC;
         attack_ff  <= `CPCR_RST_ATTACK;
      end
      else if (reg_wr_en)
      begin
         case (reg_addr)
            `CPCR_OFS_PIN_STRAP:
               pin_ctl_ff <= {reg_wdata[5:4], 1'b0, reg_wdata[2:0]} ;
            `CPCR_OFS_CLK_SRC:
               clk_src_ff <= reg_wdata;
            `CPCR_OFS_ATTACK:
               attack_ff <= reg_wdata[7:2];
            default:
               clk_src_ff <= clk_src_ff;
         endcase
      end
   end

   // pin d level only meaningful as general input in two-wire mode
   assign gpi_val = two_wire & pin_ctl_ff[5] & pins_sync[2];
   assign audio_serial_data_in = two_wire & pin_ctl_ff[4] & pins_sync[2];
   assign multifunction_pin_c_oe  = two_wire & pin_ctl_ff[2];
   // pin c level kept while disabled, so enabling shows it at once
   assign multifunction_pin_c_out = pin_ctl_ff[1];
   assign core_clock_sel          = pin_ctl_ff[0];
   assign clock_divider_input_sel = clk_src_ff[`CPCR_CDIV_SEL_MSB:`CPCR_CDIV_SEL_LSB];
   assign pll_reference_input_sel = clk_src_ff[`CPCR_PLL_SEL_MSB:`CPCR_PLL_SEL_LSB];
   assign atk_use_new             = attack_ff[5];

   // baseline attack time lookup
   function [7:0] base_ms;
      input [1:0] code;
      begin
         case (code)
            2'h0:    base_ms = `CPCR_ATK_MS_0;
            2'h1:    base_ms = `CPCR_ATK_MS_1;
            2'h2:    base_ms = `CPCR_ATK_MS_2;
            default: base_ms = `CPCR_ATK_MS_3;
         endcase
      end
   endfunction

   // one place decides which offsets answer on the control bus
   function mapped_ofs;
      input [7:0] ofs;
      begin
         mapped_ofs = (ofs == `CPCR_OFS_PIN_STRAP) ||
                      (ofs == `CPCR_OFS_CLK_SRC) ||
                      (ofs == `CPCR_OFS_ATTACK);
      end
   endfunction

   // divider decode and effective attack time
   always @*
   begin
      // codes 0 and 1 wrap to 16 and 17, the rest pass straight through
      case (clk_src_ff[`CPCR_PLLN_MSB:`CPCR_PLLN_LSB])
         4'h0:    nxt_pll_n = 5'h10;
         4'h1:    nxt_pll_n = 5'h11;
         default: nxt_pll_n = {1'b0, clk_src_ff[3:0]};
      endcase
      // largest product is 11 ms times 128, well inside sixteen bits
      if (attack_ff[5])
         nxt_attack = {8'h00, base_ms(attack_ff[4:3])} << attack_ff[2:0];
      else
         nxt_attack = {8'h00, legacy_attack_ms};
   end

   // read mux; straps and the pin d level bit read zero outside two-wire mode
   always @*
   begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `CPCR_OFS_PIN_STRAP:
            nxt_rdata = {two_wire & strap_b_ff, two_wire & strap_a_ff,
                         pin_ctl_ff[5:4], gpi_val, pin_ctl_ff[2:0]};
         `CPCR_OFS_CLK_SRC:
            nxt_rdata = clk_src_ff;
         `CPCR_OFS_ATTACK:
            nxt_rdata = {attack_ff, 2'b00};
         default:
            nxt_rdata = 8'h00;
      endcase
   end

   // registered outputs
   always @(posedge sys_clk or negedge rst_int_b)
   begin
      if (!rst_int_b)
      begin
         reg_rdata      <= 8'h00;
         reg_hit        <= 1'b0;
         pll_divider_n  <= `CPCR_RST_PLL_N;
         left_attack_ms <= 16'h0000;
      end
      else
      begin
         // read data holds between reads, so a slow host may fetch it late
         if (reg_rd_en)
            reg_rdata <= nxt_rdata;
         // hit marks offsets that answer, so a host can spot a wrong address
         reg_hit        <= (reg_rd_en | reg_wr_en) & mapped_ofs(reg_addr);
         pll_divider_n  <= nxt_pll_n;
         left_attack_ms <= nxt_attack;
      end
   end
endmodule

// ==== logic/cpcr_sync2.v ====
`timescale 1ns/1ps
// two-stage synchroniser for a bus of pin levels
module cpcr_sync2 #(
   parameter W = 1
)(
   input  wire         sys_clk,
   input  wire         rst_b,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // first stage feeds only the second
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end
      else
      begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;
endmodule
